// [rtl/sdc_lbist.sv]
// logic self-test: lfsr pattern source, parallel scan chains and signature register
`timescale 1ns/1ps
module sdc_lbist #(
	parameter int CHAINS    = 31,
	parameter int CHAIN_LEN = 4,
	parameter int RUN_CYC   = 6_000_000
) (
	input  wire logic                ref_clk_i,
	input  wire logic                nrst_i,
	input  wire logic                start_i,
	output logic                     busy_o,
	output logic                     done_o,
	output logic [CHAINS-1:0]        sig_o
);
	import sdc_pkg::*;

	logic [CHAINS-1:0] lfsr_reg;    // pattern source
	logic [CHAINS-1:0] chain_out;   // last flop of each chain
	logic [31:0]       run_reg;     // shift cycle count

	// parameter check
	if (CHAINS != 31 || CHAIN_LEN < 1 || RUN_CYC < 1) begin : g_bad
		$error("sdc_lbist: unsupported chain shape");
	end

	// one scan chain per lfsr bit, all loaded in parallel
	for (genvar c = 0; c < CHAINS; c++) begin : g_chain
		logic [CHAIN_LEN-1:0] sh_reg;
		always_ff @(posedge ref_clk_i) begin
			if (!nrst_i) begin
				sh_reg <= '0;
			end else if (busy_o) begin
				sh_reg <= {sh_reg[CHAIN_LEN-2:0], lfsr_reg[c]};
			end
		end
		assign chain_out[c] = sh_reg[CHAIN_LEN-1];
	end

	// lfsr x^31 + x^28 + 1 with nonzero seed
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || start_i) begin
			lfsr_reg <= 31'h0000_0001;
		end else if (busy_o) begin
			lfsr_reg <= {lfsr_reg[29:0], lfsr_reg[30] ^ lfsr_reg[27]};
		end
	end

	// misr compacts every chain output into the signature
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || start_i) begin
			sig_o <= '0;
		end else if (busy_o) begin
			sig_o <= {sig_o[29:0], sig_o[30] ^ sig_o[27]} ^ chain_out;
		end
	end

	// run length and done level
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			run_reg <= '0;
		end else if (start_i) begin
			busy_o  <= 1'b1;
			done_o  <= 1'b0;
			run_reg <= '0;
		end else if (busy_o) begin
			run_reg <= run_reg + 32'd1;
			if (run_reg == 32'(RUN_CYC - 1)) begin
				busy_o <= 1'b0;
				done_o <= 1'b1;
			end
		end
	end
endmodule

// [rtl/sdc_pkg.sv]
// shared constants, types and register map of the safety diagnostics block
package sdc_pkg;
	// register word indices as seen on the serial register port
	localparam logic [7:0] ADDR_SCRATCH2  = 8'h17;   // user_scratch_word2
	localparam logic [7:0] ADDR_SETUP     = 8'h1e;   // shared_setup_word
	localparam logic [7:0] ADDR_SCRATCH   = 8'h1f;   // user_scratch_word
	localparam logic [7:0] ADDR_LIN_FIRST = 8'h20;   // linearization_pair_first
	localparam logic [7:0] ADDR_LIN_LAST  = 8'h2f;   // linearization_pair_last
	localparam logic [7:0] ADDR_HEARTBEAT = 8'h80;   // heartbeat_count, extended read
	localparam logic [7:0] ADDR_CONDITION = 8'h81;   // condition_word, running and done bits
	localparam logic [7:0] ADDR_ERROR     = 8'h82;   // error flags, write one to clear
	// field positions in the shared setup word
	localparam int LOW_LIM_LSB  = 0;    // low_field_limit [5:0]
	localparam int HIGH_LIM_LSB = 6;    // high_field_limit [11:6]
	localparam int BIT_NO_HRST  = 12;   // ignore hard reset special
	localparam int BIT_NO_STST  = 13;   // ignore self-test special
	localparam int BIT_FOLLOW   = 14;   // scratch word follows exemptions
	localparam int BIT_EXEMPT   = 16;   // lock does not apply to exempt words
	localparam int BIT_WAIVE    = 17;   // unlock step not needed for exempt words
	localparam int BIT_PU_XDCR  = 18;   // transducer check at power-up
	localparam int BIT_PU_LOGIC = 19;   // logic check at power-up
	localparam int LOCK_LSB     = 20;   // write-protect code [23:20]
	// write-protect codes
	localparam logic [3:0] LOCK_NVM     = 4'h0c;   // nonvolatile writes blocked
	localparam logic [3:0] LOCK_NVM_REG = 4'h03;   // nonvolatile and indirect writes blocked
	// reset values
	localparam logic [5:0]  LOW_LIM_RST  = 6'h0d;
	localparam logic [5:0]  HIGH_LIM_RST = 6'h25;
	localparam logic [23:0] SETUP_RST    = {12'h000, HIGH_LIM_RST, LOW_LIM_RST};
	localparam logic [23:0] WORD_RST     = 24'h00_0000;
	// error flag positions
	localparam int ERR_XDCR = 0;   // transducer self-test failed
	localparam int ERR_LOW  = 1;   // field below low limit
	localparam int ERR_HIGH = 2;   // field above high limit
	localparam int ERR_OSC  = 3;   // oscillator watchdog limit violated
	localparam int ERR_LBST = 4;   // logic self-test signature mismatch
	localparam int ERR_W    = 5;
	// timing
	localparam int CLK_PERIOD_PS = 5_000;              // 200 MHz
	localparam longint ALIVE_TICK_PS = 64'd8_192_000_000;   // 8.192 ms
	localparam int ALIVE_TICK_CYC = int'(ALIVE_TICK_PS / CLK_PERIOD_PS);
	localparam longint XDCR_TEST_PS = 64'd30_000_000_000;   // 30 ms
	localparam int XDCR_STEPS = 8;
	localparam int XDCR_STEP_CYC = int'(XDCR_TEST_PS / CLK_PERIOD_PS / XDCR_STEPS);
	localparam longint LBIST_PS = 64'd30_000_000_000;       // 30 ms
	localparam int LBIST_CYC = int'(LBIST_PS / CLK_PERIOD_PS);
	// linearization scale shifts: 12-bit span onto 512 or 1024 angle codes
	localparam int LIN_SHIFT_NARROW = 3;   // +/- 22.5 degrees
	localparam int LIN_SHIFT_WIDE   = 2;   // +/- 45 degrees
	// serial register request
	typedef struct packed {
		logic        wr;      // write strobe, one cycle
		logic        rd;      // read strobe, one cycle
		logic        nvm;     // write goes to nonvolatile memory too
		logic [7:0]  addr;    // word index
		logic [23:0] wdata;   // write data
	} sdc_req_type;
	// transducer self-test sequence, gray coded
	typedef enum logic [1:0] {
		XT_IDLE = 2'b00,
		XT_RUN  = 2'b01,
		XT_DONE = 2'b11
	} sdc_xt_state_type;
endpackage

// [rtl/sdc_top.sv]
// safety diagnostics and shared setup word of the angle sensor
`timescale 1ns/1ps
// Operation
// - low limit code is gauss over 16
// - high limit code is gauss over 32
// - setup bits block hard reset, self-test specials
// - follow bit extends exemptions to scratch word
// - exempt bit keeps scratch words writable despite lock
// - waiver bit drops unlock step for scratch words
// - power-up transducer check when enabled
// - power-up logic check when enabled
// - lock codes block nvm or all writes; error-flag clears still act under either code
// - 32 signed corrections subtracted from angle
// - correction span 22.5 or 45 degrees
// - 32-bit alive counter from zero, wraps
// - alive period is cycle setting plus one
// - extended read 0x80 returns full count
// - watchdogs held cleared in sleep, restart from zero on wake
// - count other oscillator against limits
// - 31 chains loaded from 31-bit lfsr
// - misr forms 31-bit pass or fail signature
// - logic test runs beside transducer test
// - test current emulates rotating field, angle judged
// - special starts test, done or idle ends
// - fail flag set on failed transducer test
// - six-bit cycle setting gives alive rate
module sdc_top #(
	parameter int          TICK_CYC  = sdc_pkg::ALIVE_TICK_CYC,
	parameter int          STEP_CYC  = sdc_pkg::XDCR_STEP_CYC,
	parameter int          LBIST_RUN = sdc_pkg::LBIST_CYC,
	parameter int          WD_WIN    = 256,            // watchdog window, cycles
	parameter int          WD_MIN    = 8,              // least other-oscillator edges
	parameter int          WD_MAX    = 64,             // most other-oscillator edges
	parameter int          XDCR_TOL  = 64,             // angle tolerance, codes
	parameter logic [30:0] LBIST_REF = 31'h0000_0000   // expected signature
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 nrst_i,
	input  wire sdc_pkg::sdc_req_type req_i,
	input  wire logic                 unlock_i,
	input  wire logic                 spc_hard_rst_i,
	input  wire logic                 spc_self_test_i,
	input  wire logic [5:0]           lpm_cycle_i,
	input  wire logic                 lin_scale_i,
	input  wire logic                 angle_vld_i,
	input  wire logic [11:0]          angle_i,
	input  wire logic [11:0]          field_i,
	input  wire logic                 sleep_i,
	input  wire logic                 osc_other_i,
	output logic [31:0]               rdata_o,
	output logic                      rvalid_o,
	output logic                      wr_refused_o,
	output logic                      lin_vld_o,
	output logic [11:0]               lin_angle_o,
	output logic                      xt_drive_o,
	output logic                      xt_dir_o,
	output logic [1:0]                xt_elem_o,
	output logic [4:0]                err_o
);
	import sdc_pkg::*;

	// parameter check
	if (TICK_CYC < 1 || STEP_CYC < 2 || WD_WIN < 2 || WD_MIN > WD_MAX) begin : g_bad
		$error("sdc_top: unsupported timing parameters");
	end

	logic [23:0]      setup_reg;        // shared_setup_word
	logic [23:0]      scratch_reg;      // user_scratch_word
	logic [23:0]      scratch2_reg;     // user_scratch_word2
	logic [23:0]      lin_mem [16];     // correction pairs
	logic [31:0]      alive_reg;        // heartbeat_count
	logic [31:0]      tick_reg;         // 8.192 ms prescaler
	logic [5:0]       mult_reg;         // cycle setting multiplier
	logic             pwrup_reg;        // power-up or hard reset pulse
	logic             soft_rst;         // accepted hard reset special
	logic [ERR_W-1:0] err_next;
	sdc_xt_state_type xt_state;
	logic [2:0]       xt_phase_reg;     // emulated field direction step
	logic [31:0]      xt_cnt_reg;       // cycles within a step
	logic             xt_start;
	logic             xt_done_reg;      // special done
	logic             xt_bad;           // step judged out of tolerance
	logic [11:0]      xt_diff;
	logic             lb_start;
	logic             lb_busy;
	logic             lb_done;
	logic             lb_done_d;
	logic [30:0]      lb_sig;
	logic             osc_s1;           // synchroniser first flop
	logic             osc_s2;
	logic             osc_s3;
	logic [15:0]      wd_win_reg;       // window counter
	logic [15:0]      wd_edges_reg;     // other-oscillator edges in window
	logic             wd_fault;
	logic             low_hit;
	logic             high_hit;
	logic             exempt_word;      // word may use the exemptions
	logic             lock_any;
	logic             refuse;
	logic [11:0]      corr;
	logic [11:0]      corr_scaled;
	logic [3:0]       lin_idx;

	// power-up pulse after reset release, repeated for an accepted hard reset
	assign soft_rst = spc_hard_rst_i && !setup_reg[BIT_NO_HRST];
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			pwrup_reg <= 1'b1;
		end else begin
			pwrup_reg <= soft_rst;
		end
	end

	// write permission: lock code, unlock step and exempt scratch words
	assign exempt_word = (req_i.addr == ADDR_SCRATCH2) ||
		((req_i.addr == ADDR_SCRATCH) && setup_reg[BIT_FOLLOW]);
	assign lock_any = (setup_reg[LOCK_LSB+:4] == LOCK_NVM) ||
		(setup_reg[LOCK_LSB+:4] == LOCK_NVM_REG);
	always_comb begin
		refuse = 1'b0;
		if (req_i.nvm) begin
			// nonvolatile write: lock, then unlock step
			if (lock_any && !(exempt_word && setup_reg[BIT_EXEMPT])) begin
				refuse = 1'b1;
			end
			if (!unlock_i && !(exempt_word && setup_reg[BIT_WAIVE])) begin
				refuse = 1'b1;
			end
		end else if (setup_reg[LOCK_LSB+:4] == LOCK_NVM_REG) begin
			// indirect register write under full lock
			refuse = !(exempt_word && setup_reg[BIT_EXEMPT]);
		end
	end

	// register writes
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			setup_reg    <= SETUP_RST;
			scratch_reg  <= WORD_RST;
			scratch2_reg <= WORD_RST;
			wr_refused_o <= 1'b0;
		end else begin
			wr_refused_o <= req_i.wr && refuse;
			if (req_i.wr && !refuse) begin
				case (req_i.addr)
					ADDR_SETUP:    setup_reg    <= req_i.wdata;
					ADDR_SCRATCH:  scratch_reg  <= req_i.wdata;
					ADDR_SCRATCH2: scratch2_reg <= req_i.wdata;
					default: ;
				endcase
			end
		end
	end

	// correction table, two signed entries to a word
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < 16; i++) begin
				lin_mem[i] <= WORD_RST;
			end
		end else if (req_i.wr && !refuse && req_i.addr[7:4] == ADDR_LIN_FIRST[7:4]) begin
			lin_mem[req_i.addr[3:0]] <= req_i.wdata;
		end
	end

	// register reads, answered one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rdata_o  <= 32'h0000_0000;
			rvalid_o <= 1'b0;
		end else begin
			rvalid_o <= req_i.rd;
			if (req_i.rd) begin
				case (req_i.addr)
					ADDR_SETUP:     rdata_o <= {8'h00, setup_reg};
					ADDR_SCRATCH:   rdata_o <= {8'h00, scratch_reg};
					ADDR_SCRATCH2:  rdata_o <= {8'h00, scratch2_reg};
					ADDR_HEARTBEAT: rdata_o <= alive_reg;
					ADDR_CONDITION: rdata_o <= {28'h000_0000, lb_done, lb_busy,
						xt_done_reg, xt_state == XT_RUN};
					ADDR_ERROR:     rdata_o <= {27'h000_0000, err_o};
					default: begin
						if (req_i.addr[7:4] == ADDR_LIN_FIRST[7:4]) begin
							rdata_o <= {8'h00, lin_mem[req_i.addr[3:0]]};
						end else begin
							rdata_o <= 32'h0000_0000;   // unmapped
						end
					end
				endcase
			end
		end
	end

	// alive counter: prescaler, then cycle setting plus one ticks per count
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || soft_rst) begin
			tick_reg  <= '0;
			mult_reg  <= '0;
			alive_reg <= 32'h0000_0000;
		end else if (tick_reg == 32'(TICK_CYC - 1)) begin
			tick_reg <= '0;
			if (mult_reg >= lpm_cycle_i) begin
				mult_reg  <= '0;
				alive_reg <= alive_reg + 32'd1;
			end else begin
				mult_reg <= mult_reg + 6'd1;
			end
		end else begin
			tick_reg <= tick_reg + 32'd1;
		end
	end

	// linearization: boundary correction of the angle's segment, scaled and subtracted
	assign lin_idx = angle_i[11:8];
	assign corr = angle_i[7] ? lin_mem[lin_idx][23:12] : lin_mem[lin_idx][11:0];
	assign corr_scaled = lin_scale_i ? 12'($signed(corr) >>> LIN_SHIFT_WIDE)
		: 12'($signed(corr) >>> LIN_SHIFT_NARROW);
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			lin_vld_o   <= 1'b0;
			lin_angle_o <= 12'h000;
		end else begin
			lin_vld_o <= angle_vld_i;
			if (angle_vld_i) begin
				lin_angle_o <= angle_i - corr_scaled;
			end
		end
	end

	// field comparators, zero code disables each
	assign low_hit = (setup_reg[LOW_LIM_LSB+:6] != 6'h00) &&
		(field_i < {2'b00, setup_reg[LOW_LIM_LSB+:6], 4'h0});
	assign high_hit = (setup_reg[HIGH_LIM_LSB+:6] != 6'h00) &&
		(field_i > {1'b0, setup_reg[HIGH_LIM_LSB+:6], 5'h00});

	// other oscillator pin: two flops, then edge detect on the second
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_s3 <= 1'b0;
		end else begin
			osc_s1 <= osc_other_i;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
		end
	end

	// watchdog: count other-domain edges per window, cleared while asleep
	assign wd_fault = (wd_win_reg == 16'(WD_WIN - 1)) &&
		((wd_edges_reg < 16'(WD_MIN)) || (wd_edges_reg > 16'(WD_MAX)));
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || sleep_i) begin
			wd_win_reg   <= '0;
			wd_edges_reg <= '0;
		end else if (wd_win_reg == 16'(WD_WIN - 1)) begin
			wd_win_reg   <= '0;
			wd_edges_reg <= '0;
		end else begin
			wd_win_reg <= wd_win_reg + 16'd1;
			if (osc_s2 && !osc_s3 && wd_edges_reg != 16'hffff) begin
				wd_edges_reg <= wd_edges_reg + 16'd1;
			end
		end
	end

	// logic self-test, independent of the transducer sequence
	assign lb_start = pwrup_reg && setup_reg[BIT_PU_LOGIC];
	sdc_lbist #(
		.CHAINS    (31),
		.CHAIN_LEN (4),
		.RUN_CYC   (LBIST_RUN)
	) u_lbist (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.start_i   (lb_start),
		.busy_o    (lb_busy),
		.done_o    (lb_done),
		.sig_o     (lb_sig)
	);
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			lb_done_d <= 1'b0;
		end else begin
			lb_done_d <= lb_done;
		end
	end

	// transducer self-test: eight steps of test current, angle checked per step
	assign xt_start = (xt_state != XT_RUN) && ((pwrup_reg && setup_reg[BIT_PU_XDCR]) ||
		(spc_self_test_i && !setup_reg[BIT_NO_STST]));
	assign xt_diff = angle_i - {xt_phase_reg, 9'h000};
	assign xt_bad = (xt_state == XT_RUN) && (xt_cnt_reg == 32'(STEP_CYC - 1)) &&
		(xt_diff > 12'(XDCR_TOL)) && (xt_diff < 12'(4096 - XDCR_TOL));
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			xt_state     <= XT_IDLE;
			xt_phase_reg <= 3'd0;
			xt_cnt_reg   <= '0;
			xt_done_reg  <= 1'b0;
		end else begin
			case (xt_state)
				XT_IDLE, XT_DONE: begin
					if (xt_start) begin
						xt_state     <= XT_RUN;
						xt_phase_reg <= 3'd0;
						xt_cnt_reg   <= '0;
						xt_done_reg  <= 1'b0;
					end
				end
				XT_RUN: begin
					if (xt_cnt_reg == 32'(STEP_CYC - 1)) begin
						xt_cnt_reg   <= '0;
						xt_phase_reg <= xt_phase_reg + 3'd1;
						if (xt_phase_reg == 3'(XDCR_STEPS - 1)) begin
							xt_state    <= XT_DONE;
							xt_done_reg <= 1'b1;
						end
					end else begin
						xt_cnt_reg <= xt_cnt_reg + 32'd1;
					end
				end
				default: xt_state <= XT_IDLE;
			endcase
		end
	end

	// test current: direction flips each half turn, element pair walks
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			xt_drive_o <= 1'b0;
			xt_dir_o   <= 1'b0;
			xt_elem_o  <= 2'b00;
		end else begin
			xt_drive_o <= (xt_state == XT_RUN);
			xt_dir_o   <= xt_phase_reg[2];
			xt_elem_o  <= xt_phase_reg[1:0];
		end
	end

	// sticky error flags, write one to clear, a new event wins over the clear
	always_comb begin
		err_next = err_o;
		if (req_i.wr && req_i.addr == ADDR_ERROR) begin
			err_next = err_o & ~req_i.wdata[ERR_W-1:0];
		end
		err_next[ERR_XDCR] = err_next[ERR_XDCR] | xt_bad;
		err_next[ERR_LOW]  = err_next[ERR_LOW] | low_hit;
		err_next[ERR_HIGH] = err_next[ERR_HIGH] | high_hit;
		err_next[ERR_OSC]  = err_next[ERR_OSC] | wd_fault;
		err_next[ERR_LBST] = err_next[ERR_LBST] | (lb_done && !lb_done_d && lb_sig != LBIST_REF);
	end
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			err_o <= '0;
		end else begin
			err_o <= err_next;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);

	a_low_field_flag: assert property (low_hit |=> err_o[ERR_LOW])
		else $error("low field not flagged");
	a_high_field_off: assert property (
		(setup_reg[HIGH_LIM_LSB+:6] == 6'h00) |-> !high_hit)
		else $error("disabled high limit still hits");
	a_hard_rst_block: assert property (
		spc_hard_rst_i && setup_reg[BIT_NO_HRST] |=> !pwrup_reg)
		else $error("blocked hard reset acted");
	a_lock_refuses: assert property (
		req_i.wr && req_i.nvm && lock_any && !exempt_word |=> wr_refused_o)
		else $error("locked nvm write accepted");
	a_exempt_write: assert property (
		req_i.wr && req_i.nvm && unlock_i && exempt_word && setup_reg[BIT_EXEMPT]
		|=> !wr_refused_o)
		else $error("exempt word write refused");
	a_unlock_waiver: assert property (
		req_i.wr && req_i.nvm && !unlock_i && !lock_any && exempt_word
		&& setup_reg[BIT_WAIVE] |=> !wr_refused_o)
		else $error("waived write refused");
	a_alive_steps: assert property (
		!$past(soft_rst) && alive_reg != $past(alive_reg) |-> alive_reg == $past(alive_reg) + 32'd1)
		else $error("alive counter jumped");
	a_alive_read: assert property (
		req_i.rd && req_i.addr == ADDR_HEARTBEAT |=> rvalid_o && rdata_o == $past(alive_reg))
		else $error("heartbeat read wrong");
	a_lin_result: assert property (
		angle_vld_i |=> lin_angle_o == $past(angle_i) - $past(corr_scaled))
		else $error("linearized angle wrong");
	a_wd_sleep_clear: assert property (sleep_i |=> wd_edges_reg == 16'h0000 && !wd_fault)
		else $error("watchdog counted in sleep");
	a_xt_end_done: assert property (
		xt_state == XT_RUN ##1 xt_state != XT_RUN |-> xt_done_reg ##1 !xt_drive_o)
		else $error("self-test end without done");
	a_xt_fail_flag: assert property (xt_bad |=> err_o[ERR_XDCR])
		else $error("self-test failure lost");

	c_xt_complete: cover property (xt_state == XT_RUN ##1 xt_state == XT_DONE);
	c_both_tests: cover property (lb_busy && xt_state == XT_RUN);
	c_exempt_lock: cover property (req_i.wr && lock_any && exempt_word && !refuse);
	c_alive_tick: cover property (alive_reg == 32'd2);
endmodule

// [tb/sdc_host.sv]
// host model driving the serial register port and the self-test special
`timescale 1ns/1ps
module sdc_host (
	input  wire logic            ref_clk_i,
	input  wire logic [31:0]     rdata_i,
	input  wire logic            rvalid_i,
	input  wire logic            refused_i,
	output sdc_pkg::sdc_req_type req_o,
	output logic                 spc_o
);
	import sdc_pkg::*;
	logic [31:0] rd_val;   // last read data
	logic        rv;       // read strobe seen
	logic        rf;       // refusal strobe seen
	initial req_o = '0;
	initial spc_o = 1'b0;
	// write taken at one edge, refusal strobe stands for the cycle after it
	task automatic wr(input logic [7:0] a, input logic [23:0] d, input logic n);
		@(negedge ref_clk_i);
		req_o <= '{1'b1, 1'b0, n, a, d};
		@(negedge ref_clk_i);
		rf = refused_i;
		req_o.wr <= 1'b0;
	endtask
	// read, data taken in the cycle its strobe stands
	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk_i);
		req_o <= '{1'b0, 1'b1, 1'b0, a, 24'h00_0000};
		@(negedge ref_clk_i);
		rd_val = rdata_i;
		rv = rvalid_i;
		req_o.rd <= 1'b0;
	endtask
	// flag cleared, special sent, then a bounded poll for the end
	task automatic self_test(output logic done);
		wr(ADDR_ERROR, 24'h00_001f, 1'b0);
		@(negedge ref_clk_i);
		spc_o <= 1'b1;
		@(negedge ref_clk_i);
		spc_o <= 1'b0;
		done = 1'b0;
		for (int i = 0; i < 40 && !done; i++) begin
			rd(ADDR_CONDITION);
			done = rd_val[1] | ~rd_val[0];
		end
	endtask
endmodule

// [tb/tb.sv]
// self-checking bench of the safety diagnostics block
`timescale 1ns/1ps
module tb;
	import sdc_pkg::*;
	localparam int TICK = 4;                            // shortened alive prescale
	logic        ref_clk_i, nrst_i, unlock, spc, scale;  // clock, reset, controls
	logic        vld, osc, rvalid, refused, lin_vld, done;
	logic [11:0] angle, field, lin_angle;                // angle and field paths
	logic [5:0]  lpm;                                    // alive rate setting
	logic [31:0] rdata, a0;                              // read data, first count
	logic [4:0]  err;                                    // sticky error flags
	sdc_req_type req;                                    // host request
	logic [23:0] mem [256];                              // expected word contents
	int          n_fail = 0;                             // mismatches
	int          cmp_count = 0;                          // comparisons
	sdc_top #(.TICK_CYC(TICK), .STEP_CYC(8), .LBIST_RUN(20)) i_sdc_top (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req), .unlock_i(unlock),
		.spc_hard_rst_i(1'b0), .spc_self_test_i(spc), .lpm_cycle_i(lpm),
		.lin_scale_i(scale), .angle_vld_i(vld), .angle_i(angle), .field_i(field),
		.sleep_i(1'b0), .osc_other_i(osc), .rdata_o(rdata), .rvalid_o(rvalid),
		.wr_refused_o(refused), .lin_vld_o(lin_vld), .lin_angle_o(lin_angle),
		.xt_drive_o(), .xt_dir_o(), .xt_elem_o(), .err_o(err));
	sdc_host i_sdc_host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.refused_i(refused), .req_o(req), .spc_o(spc));
	// 200 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	// other oscillator, period of 16 clocks, phase unrelated
	initial begin
		osc = 1'b0;
		#1.3;
		forever #40 osc = ~osc;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// limits at their boundaries, clearing, then both comparators off
	task automatic t_field;
		logic [48:0] ft [5] = '{{12'd207, 8'h82, 24'h00_0000, 5'h02},
			{12'd1185, 8'h82, 24'h00_0002, 5'h04}, {12'd208, 8'h82, 24'h00_0004, 5'h00},
			{12'd1184, 8'h1e, 24'h00_0000, 5'h00}, {12'd0, 8'h82, 24'h00_0000, 5'h00}};
		i_sdc_host.rd(ADDR_SETUP);
		chk("setup reset", i_sdc_host.rd_val, 32'h0000_094d);
		foreach (ft[i]) begin
			field = ft[i][48:37];
			i_sdc_host.wr(ft[i][36:29], ft[i][28:5], 1'b0);
			chk("field err", err, ft[i][4:0]);
		end
	endtask
	// transducer test with an angle that cannot follow the emulated field
	task automatic t_xt;
		angle = 12'h800;
		i_sdc_host.self_test(done);
		chk("test done", done, 1'b1);
		if (done !== 1'b1)
			close_out();
		chk("test fail", err, 5'h01);
	endtask
	// writes under unlock, waiver, exemption and both lock codes, read back
	task automatic t_regs;
		logic [34:0] tw [15] = '{{3'b011, 8'h1f, 24'h12_3456},
			{3'b101, 8'h20, 24'h80_0100}, {3'b000, 8'h1e, 24'h02_4965},
			{3'b001, 8'h1f, 24'h12_3456}, {3'b011, 8'h21, 24'h00_0111},
			{3'b000, 8'h2f, 24'h7f_ff00}, {3'b000, 8'h1e, 24'hc2_4965},
			{3'b111, 8'h17, 24'h00_abcd}, {3'b000, 8'h1e, 24'hc3_4965},
			{3'b001, 8'h17, 24'h00_abcd}, {3'b000, 8'h21, 24'h00_0555},
			{3'b000, 8'h1e, 24'h33_6965}, {3'b010, 8'h21, 24'h00_0666},
			{3'b000, 8'h1f, 24'h00_0777}, {3'b010, 8'h1e, 24'h00_0965}};
		foreach (tw[i]) begin
			unlock = tw[i][34];
			i_sdc_host.wr(tw[i][31:24], tw[i][23:0], tw[i][32]);
			chk("refused", i_sdc_host.rf, tw[i][33]);
			if (!tw[i][33])
				mem[tw[i][31:24]] = tw[i][23:0];
			i_sdc_host.rd(tw[i][31:24]);
			chk("readback", i_sdc_host.rd_val, {8'h00, mem[tw[i][31:24]]});
		end
		i_sdc_host.rd(8'h3a);
		chk("unmapped valid", i_sdc_host.rv, 32'h0000_0001);
		chk("unmapped", i_sdc_host.rd_val, 32'h0000_0000);
	endtask
	// back-to-back angles at the outer segments, both scales
	task automatic t_lin;
		logic [24:0] lt [8] = '{{1'b0, 12'h010, 12'hff0}, {1'b1, 12'h010, 12'hfd0},
			{1'b0, 12'h090, 12'h190}, {1'b1, 12'h090, 12'h290}, {1'b0, 12'hf80, 12'he81},
			{1'b1, 12'hf80, 12'hd81}, {1'b0, 12'hf10, 12'hf30}, {1'b1, 12'hf10, 12'hf50}};
		for (int i = 0; i <= 8; i++) begin
			@(negedge ref_clk_i);
			if (i > 0)
				chk("lin", {lin_vld, lin_angle}, {1'b1, lt[i-1][11:0]});
			vld = (i < 8);
			if (i < 8)
				{scale, angle} = lt[i][24:12];
		end
	endtask
	// self-test special while its block bit is set must not start a test
	task automatic t_block;
		i_sdc_host.self_test(done);
		chk("blocked", i_sdc_host.rd_val[1:0], 2'b10);
	endtask
	// alive count over 96 cycles for several cycle settings
	task automatic t_alive;
		logic [5:0] lv [4] = '{6'd0, 6'd1, 6'd2, 6'd5};
		foreach (lv[i]) begin
			lpm = lv[i];
			repeat (48) @(negedge ref_clk_i);
			i_sdc_host.rd(ADDR_HEARTBEAT);
			a0 = i_sdc_host.rd_val;
			repeat (94) @(negedge ref_clk_i);
			i_sdc_host.rd(ADDR_HEARTBEAT);
			chk("alive", i_sdc_host.rd_val - a0, 32'(96 / (TICK * (lv[i] + 1))));
		end
	endtask
	// reset, then each scenario in turn
	initial begin
		{nrst_i, unlock, scale, vld, angle, lpm} = '0;
		field = 12'd500;
		foreach (mem[i]) mem[i] = WORD_RST;
		repeat (6) @(negedge ref_clk_i);
		nrst_i = 1'b1;
		t_field();
		t_xt();
		t_regs();
		t_lin();
		t_block();
		t_alive();
		close_out();
	end
endmodule
